// ==== rtl/tf_regs.vh ====
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 8-bit registers reached over a byte-wide register port
// Notes: reset values are plain defaults that give a working filter
`ifndef TF_REGS_VH
`define TF_REGS_VH
`define TF_ADDR_MAX_VAR 8'h26
`define TF_ADDR_DRIFT_STEP 8'h27
`define TF_ADDR_DRIFT_LIM 8'h28
`define TF_ADDR_PAD0_TOUCH 8'h29
`define TF_ADDR_PAD0_REL 8'h2a
`define TF_ADDR_PAD1_TOUCH 8'h2b
`define TF_ADDR_PAD1_REL 8'h2c
`define TF_ADDR_PAD2_TOUCH 8'h2d
`define TF_ADDR_PAD2_REL 8'h2e
`define TF_ADDR_AFE_CFG 8'h41
`define TF_ADDR_FILT_CFG 8'h43
`define TF_S1_CNT_MSB 7
`define TF_S1_CNT_LSB 6
`define TF_CHARGE_MSB 7
`define TF_CHARGE_LSB 5
`define TF_S2_CNT_MSB 4
`define TF_S2_CNT_LSB 3
`define TF_INTERVAL_MSB 2
`define TF_INTERVAL_LSB 0
`define TF_RST_MAX_VAR 6'h01
`define TF_RST_DRIFT_STEP 6'h01
`define TF_RST_DRIFT_LIM 4'h0
`define TF_RST_TRIP 8'h00
`define TF_RST_AFE_CFG 8'h00
`define TF_RST_FILT_CFG 8'h20
`define TF_CLK_MHZ 125
`define TF_CHARGE_BASE_NS 500
`define TF_INTERVAL_BASE_US 1000
`define TF_MS_CYCLES (`TF_INTERVAL_BASE_US * `TF_CLK_MHZ)
`endif

// ==== rtl/tf_divider.v ====
// Purpose: sequential restoring divider, 16-bit dividend by 6-bit divisor
// Assumes: divisor is never zero; start is ignored while busy
// Notes: one quotient bit per clock, done pulses 17 edges after start
`default_nettype none
module tf_divider (
  input wire ref_clk,
  input wire rst,
  input wire start,
  input wire [15:0] dividend,
  input wire [5:0] divisor,
  output wire busy,
  output reg done,
  output wire [15:0] quotient
);
  reg [15:0] q_reg;
  reg [5:0] r_reg;
  reg [5:0] d_reg;
  reg [4:0] cnt_reg;
  wire [6:0] trial = {r_reg, q_reg[15]};
  wire fits = trial >= {1'b0, d_reg};
  wire [6:0] diff = trial - {1'b0, d_reg};
  assign busy = cnt_reg != 5'h00;
  assign quotient = q_reg;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q_reg <= 16'h0000;
      r_reg <= 6'h00;
      d_reg <= 6'h01;
      cnt_reg <= 5'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy && start) begin
        q_reg <= dividend;
        r_reg <= 6'h00;
        d_reg <= divisor;
        cnt_reg <= 5'h10;
      end else if (busy) begin
        // remainder stays below the divisor, so six bits hold it
        r_reg <= fits ? diff[5:0] : trial[5:0];
        q_reg <= {q_reg[14:0], fits};
        cnt_reg <= cnt_reg - 5'h01;
        done <= cnt_reg == 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/tf_baseline.v ====
// Purpose: one pad's baseline filter and touch/release decision
// Assumes: upd pulses once per new filtered value
// Notes: the first value after reset seeds the baseline
`default_nettype none
module tf_baseline (
  input wire ref_clk,
  input wire rst,
  input wire upd,
  input wire [9:0] filt,
  input wire [5:0] max_var,
  input wire [5:0] step,
  input wire [3:0] lim,
  input wire [7:0] touch_trip,
  input wire [7:0] release_trip,
  output reg [9:0] base,
  output reg touched,
  output reg event_pulse
);
  reg seeded_reg;
  reg dir_reg;
  reg [3:0] cnt_reg;
  wire signed [10:0] delta = $signed({1'b0, base}) - $signed({1'b0, filt});
  wire up = filt > base;
  wire [9:0] mag = up ? filt - base : base - filt;
  wire [3:0] cnt_next = (cnt_reg != 4'h0 && dir_reg == up) ? cnt_reg + 4'h1 : 4'h1;
  // code n asks for n+1 samples; the top code stays at fifteen
  wire [3:0] lim_eff = (lim == 4'hf) ? 4'hf : lim + 4'h1;
  wire [9:0] stepped = up ? base + {4'h0, step} : base - {4'h0, step};
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      base <= 10'h000;
      touched <= 1'b0;
      event_pulse <= 1'b0;
      seeded_reg <= 1'b0;
      dir_reg <= 1'b0;
      cnt_reg <= 4'h0;
    end else begin
      event_pulse <= 1'b0;
      if (upd) begin
        if (!seeded_reg) begin
          base <= filt;
          seeded_reg <= 1'b1;
        end else if (touched) begin
          // baseline holds while touched
          if (delta <= $signed({3'b000, release_trip})) begin
            touched <= 1'b0;
            event_pulse <= 1'b1;
          end
        end else if (touch_trip != 8'h00 &&
                     delta >= $signed({3'b000, touch_trip})) begin
          touched <= 1'b1;
          event_pulse <= 1'b1;
          cnt_reg <= 4'h0;
        end else if (mag <= {4'h0, max_var}) begin
          base <= filt;
          cnt_reg <= 4'h0;
        end else begin
          dir_reg <= up;
          if (cnt_next >= lim_eff) begin
            // never step past the filtered value
            base <= (mag <= {4'h0, step}) ? filt : stepped;
            cnt_reg <= 4'h0;
          end else begin
            cnt_reg <= cnt_next;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/tf_touch_filter.v ====
// Purpose: three-stage filtering and touch detection for three pads
// Assumes: register port fed by a serial-bus slave on ref_clk; adc_data valid
//   at the end of each charge phase
// Notes: open-drain interrupt output, released by a host read transaction unless a new event comes in the same cycle
// How it works
// - each pad runs through short averager, long averager and baseline stage
// - first stage averages six to thirty-four consecutive raw conversions
// - two-bit first-stage count code picks 6, 10, 18 or 34 samples
// - first-stage sample spacing follows the programmed charge time
// - second stage averages 4, 6, 10 or 18 first-stage results
// - three-bit charge time code gives 0.5 us doubling to 32 us
// - second-stage result is presented as filtered data per pad
// - third stage acts as the touch baseline filter
// - baseline freezes while touched and resumes after release
// - six-bit max variation limits what passes into the baseline
// - six-bit drift step sets how far baseline moves on real drift
// - four-bit count of consecutive over-limit samples, code 0 meaning one
// - touch when baseline minus filtered value reaches a nonzero touch trip
// - touch or release updates status and raises interrupt; a touch freezes baseline
// - eight-bit touch trips per pad at 0x29, 0x2b, 0x2d
// - eight-bit release trips at 0x2a, 0x2c, 0x2e, release at or below
// - interrupt is open-drain, latched low, cleared by a host read
`include "tf_regs.vh"
`default_nettype none
module tf_touch_filter #(
  parameter SAMPLE_TICK_CYCLES = `TF_MS_CYCLES,
  parameter NUM_PADS = 3
) (
  input wire ref_clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire host_read_done,
  output reg [1:0] pad_sel,
  output wire charge_en,
  output wire discharge_en,
  output wire adc_capture,
  input wire [9:0] adc_data,
  output wire [2:0] touch_status,
  output reg [29:0] filtered_data,
  output wire [29:0] baseline_data,
  output wire irq_out,
  output wire irq_oe_n
);
  localparam ST_IDLE = 3'd0;
  localparam ST_CHARGE = 3'd1;
  localparam ST_DISCH = 3'd2;
  localparam ST_DIV1 = 3'd3;
  localparam ST_DIV2 = 3'd4;
  localparam ST_NEXT = 3'd5;
  localparam [16:0] TICK_LAST = SAMPLE_TICK_CYCLES - 1;

  // round up to whole cycles; code 0 is not a valid time and acts as code 1
  function [11:0] charge_cycles;
    input [2:0] code;
    integer c;
    integer t;
    begin
      c = (code == 3'd0) ? 1 : code;
      t = ((`TF_CHARGE_BASE_NS << (c - 1)) * `TF_CLK_MHZ + 999) / 1000;
      charge_cycles = t[11:0];
    end
  endfunction

  function [5:0] s1_count;
    input [1:0] code;
    begin
      case (code)
        2'b00: s1_count = 6'd6;
        2'b01: s1_count = 6'd10;
        2'b10: s1_count = 6'd18;
        default: s1_count = 6'd34;
      endcase
    end
  endfunction

  function [5:0] s2_count;
    input [1:0] code;
    begin
      case (code)
        2'b00: s2_count = 6'd4;
        2'b01: s2_count = 6'd6;
        2'b10: s2_count = 6'd10;
        default: s2_count = 6'd18;
      endcase
    end
  endfunction

  reg [5:0] max_var_reg;
  reg [5:0] drift_step_reg;
  reg [3:0] drift_lim_reg;
  reg [23:0] touch_trip_reg;
  reg [23:0] release_trip_reg;
  reg [7:0] afe_cfg_reg;
  reg [7:0] filt_cfg_reg;
  reg [7:0] cfg_lat_reg;
  reg [7:0] afe_lat_reg;
  reg [2:0] state_reg;
  reg [11:0] cyc_reg;
  reg [5:0] n1_reg;
  reg [15:0] sum1_reg;
  reg [15:0] acc2_reg [0:2];
  reg [4:0] cnt2_reg [0:2];
  reg [16:0] ms_cnt_reg;
  reg [6:0] int_cnt_reg;
  reg div_start_reg;
  reg [15:0] div_num_reg;
  reg [5:0] div_den_reg;
  reg [2:0] upd_reg;
  reg irq_reg;
  wire div_done;
  wire [15:0] div_q;
  wire [2:0] touched_vec;
  wire [2:0] event_vec;
  wire ms_tick;
  wire [6:0] int_last;
  wire round_go;
  wire [11:0] charge_last;
  wire [5:0] n1_total;
  wire [5:0] n2_total;
  wire [15:0] acc2_sum;
  integer i;

  assign ms_tick = ms_cnt_reg == TICK_LAST;
  assign int_last = (7'h01 << filt_cfg_reg[`TF_INTERVAL_MSB:`TF_INTERVAL_LSB]) - 7'h01;
  assign round_go = ms_tick && int_cnt_reg >= int_last;
  assign charge_last = charge_cycles(cfg_lat_reg[`TF_CHARGE_MSB:`TF_CHARGE_LSB]) - 12'h001;
  assign n1_total = s1_count(afe_lat_reg[`TF_S1_CNT_MSB:`TF_S1_CNT_LSB]);
  assign n2_total = s2_count(cfg_lat_reg[`TF_S2_CNT_MSB:`TF_S2_CNT_LSB]);
  assign acc2_sum = acc2_reg[pad_sel] + {6'h00, div_q[9:0]};
  assign charge_en = state_reg == ST_CHARGE;
  assign discharge_en = state_reg == ST_DISCH;
  assign adc_capture = charge_en && cyc_reg == charge_last;
  assign touch_status = touched_vec;
  // pin is only ever pulled low; the pull-up gives the released level
  assign irq_out = 1'b0;
  assign irq_oe_n = ~irq_reg;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ms_cnt_reg <= 17'h00000;
      int_cnt_reg <= 7'h00;
    end else begin
      ms_cnt_reg <= ms_tick ? 17'h00000 : ms_cnt_reg + 17'h00001;
      if (ms_tick) begin
        int_cnt_reg <= round_go ? 7'h00 : int_cnt_reg + 7'h01;
      end
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      max_var_reg <= `TF_RST_MAX_VAR;
      drift_step_reg <= `TF_RST_DRIFT_STEP;
      drift_lim_reg <= `TF_RST_DRIFT_LIM;
      touch_trip_reg <= {3{`TF_RST_TRIP}};
      release_trip_reg <= {3{`TF_RST_TRIP}};
      afe_cfg_reg <= `TF_RST_AFE_CFG;
      filt_cfg_reg <= `TF_RST_FILT_CFG;
    end else if (reg_wr) begin
      case (reg_addr)
        `TF_ADDR_MAX_VAR: max_var_reg <= reg_wdata[5:0];
        `TF_ADDR_DRIFT_STEP: drift_step_reg <= reg_wdata[5:0];
        `TF_ADDR_DRIFT_LIM: drift_lim_reg <= reg_wdata[3:0];
        `TF_ADDR_PAD0_TOUCH: touch_trip_reg[7:0] <= reg_wdata;
        `TF_ADDR_PAD1_TOUCH: touch_trip_reg[15:8] <= reg_wdata;
        `TF_ADDR_PAD2_TOUCH: touch_trip_reg[23:16] <= reg_wdata;
        `TF_ADDR_PAD0_REL: release_trip_reg[7:0] <= reg_wdata;
        `TF_ADDR_PAD1_REL: release_trip_reg[15:8] <= reg_wdata;
        `TF_ADDR_PAD2_REL: release_trip_reg[23:16] <= reg_wdata;
        `TF_ADDR_AFE_CFG: afe_cfg_reg <= reg_wdata;
        `TF_ADDR_FILT_CFG: filt_cfg_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `TF_ADDR_MAX_VAR: reg_rdata <= {2'b00, max_var_reg};
        `TF_ADDR_DRIFT_STEP: reg_rdata <= {2'b00, drift_step_reg};
        `TF_ADDR_DRIFT_LIM: reg_rdata <= {4'h0, drift_lim_reg};
        `TF_ADDR_PAD0_TOUCH: reg_rdata <= touch_trip_reg[7:0];
        `TF_ADDR_PAD1_TOUCH: reg_rdata <= touch_trip_reg[15:8];
        `TF_ADDR_PAD2_TOUCH: reg_rdata <= touch_trip_reg[23:16];
        `TF_ADDR_PAD0_REL: reg_rdata <= release_trip_reg[7:0];
        `TF_ADDR_PAD1_REL: reg_rdata <= release_trip_reg[15:8];
        `TF_ADDR_PAD2_REL: reg_rdata <= release_trip_reg[23:16];
        `TF_ADDR_AFE_CFG: reg_rdata <= afe_cfg_reg;
        `TF_ADDR_FILT_CFG: reg_rdata <= filt_cfg_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // measurement sequencer; config is latched per round so a write mid-round
  // cannot leave a first-stage sum divided by the wrong count
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      pad_sel <= 2'b00;
      cyc_reg <= 12'h000;
      n1_reg <= 6'h00;
      sum1_reg <= 16'h0000;
      cfg_lat_reg <= `TF_RST_FILT_CFG;
      afe_lat_reg <= `TF_RST_AFE_CFG;
      div_start_reg <= 1'b0;
      div_num_reg <= 16'h0000;
      div_den_reg <= 6'h01;
      upd_reg <= 3'b000;
      filtered_data <= 30'h00000000;
      for (i = 0; i < 3; i = i + 1) begin
        acc2_reg[i] <= 16'h0000;
        cnt2_reg[i] <= 5'h00;
      end
    end else begin
      div_start_reg <= 1'b0;
      upd_reg <= 3'b000;
      case (state_reg)
        ST_IDLE: begin
          if (round_go) begin
            cfg_lat_reg <= filt_cfg_reg;
            afe_lat_reg <= afe_cfg_reg;
            pad_sel <= 2'b00;
            n1_reg <= 6'h00;
            sum1_reg <= 16'h0000;
            cyc_reg <= 12'h000;
            state_reg <= ST_CHARGE;
          end
        end
        ST_CHARGE: begin
          cyc_reg <= cyc_reg + 12'h001;
          if (adc_capture) begin
            sum1_reg <= sum1_reg + {6'h00, adc_data};
            cyc_reg <= 12'h000;
            state_reg <= ST_DISCH;
          end
        end
        ST_DISCH: begin
          cyc_reg <= cyc_reg + 12'h001;
          if (cyc_reg == charge_last) begin
            cyc_reg <= 12'h000;
            if (n1_reg == n1_total - 6'h01) begin
              div_num_reg <= sum1_reg;
              div_den_reg <= n1_total;
              div_start_reg <= 1'b1;
              state_reg <= ST_DIV1;
            end else begin
              n1_reg <= n1_reg + 6'h01;
              state_reg <= ST_CHARGE;
            end
          end
        end
        ST_DIV1: begin
          if (div_done) begin
            if (cnt2_reg[pad_sel] == n2_total[4:0] - 5'h01) begin
              div_num_reg <= acc2_sum;
              div_den_reg <= n2_total;
              div_start_reg <= 1'b1;
              state_reg <= ST_DIV2;
            end else begin
              acc2_reg[pad_sel] <= acc2_sum;
              cnt2_reg[pad_sel] <= cnt2_reg[pad_sel] + 5'h01;
              state_reg <= ST_NEXT;
            end
          end
        end
        ST_DIV2: begin
          if (div_done) begin
            filtered_data[pad_sel * 10 +: 10] <= div_q[9:0];
            upd_reg[pad_sel] <= 1'b1;
            acc2_reg[pad_sel] <= 16'h0000;
            cnt2_reg[pad_sel] <= 5'h00;
            state_reg <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          if (pad_sel == NUM_PADS - 1) begin
            state_reg <= ST_IDLE;
          end else begin
            pad_sel <= pad_sel + 2'b01;
            n1_reg <= 6'h00;
            sum1_reg <= 16'h0000;
            state_reg <= ST_CHARGE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // a new event in the same cycle as a host read keeps the line asserted
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else if (|event_vec) begin
      irq_reg <= 1'b1;
    end else if (host_read_done) begin
      irq_reg <= 1'b0;
    end
  end

  tf_divider u_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(div_start_reg),
    .dividend(div_num_reg),
    .divisor(div_den_reg),
    .busy(),
    .done(div_done),
    .quotient(div_q)
  );

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_pad
      tf_baseline u_base (
        .ref_clk(ref_clk),
        .rst(rst),
        .upd(upd_reg[g]),
        .filt(filtered_data[g * 10 +: 10]),
        .max_var(max_var_reg),
        .step(drift_step_reg),
        .lim(drift_lim_reg),
        .touch_trip(touch_trip_reg[g * 8 +: 8]),
        .release_trip(release_trip_reg[g * 8 +: 8]),
        .base(baseline_data[g * 10 +: 10]),
        .touched(touched_vec[g]),
        .event_pulse(event_vec[g])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// ==== sim/tf_touch_filter_chk.sv ====
// Purpose: port-level assertions for the touch filter
// Assumes: single clock ref_clk, rst asynchronous active high
// Notes: bound to every tf_touch_filter instance
`default_nettype none
module tf_touch_filter_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic host_read_done,
  input wire logic [1:0] pad_sel,
  input wire logic charge_en,
  input wire logic discharge_en,
  input wire logic adc_capture,
  input wire logic [2:0] touch_status,
  input wire logic [29:0] baseline_data,
  input wire logic irq_out,
  input wire logic irq_oe_n
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  chk_phase_overlap: assert property (!(charge_en && discharge_en))
    else $error("charge and discharge overlap");
  chk_capture_last: assert property (adc_capture |-> charge_en ##1 (discharge_en && !charge_en))
    else $error("capture not on last charge cycle");
  chk_capture_pulse: assert property (adc_capture |=> !adc_capture)
    else $error("capture longer than one cycle");
  chk_pad_range: assert property (pad_sel <= 2'h2)
    else $error("pad select out of range");
  chk_event_irq: assert property ($changed(touch_status) |-> ##[0:3] !irq_oe_n)
    else $error("status change without interrupt");
  chk_read_clear: assert property (host_read_done && !$changed(touch_status) |=> irq_oe_n)
    else $error("host read did not release interrupt");
  chk_irq_latch: assert property (!irq_oe_n && !host_read_done |=> !irq_oe_n)
    else $error("interrupt released without host read");
  chk_irq_drive: assert property (irq_out == 1'b0)
    else $error("interrupt pin drives high");
  chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  chk_freeze_base: assert property (touch_status[0] && $past(touch_status[0]) |-> $stable(baseline_data[9:0]))
    else $error("baseline moved while touched");
  chk_unused_zero: assert property (reg_rd && reg_addr == 8'h26 |=> reg_rdata[7:6] == 2'h0)
    else $error("unused variation bits read nonzero");
  cover property ($rose(touch_status[0]));
  cover property (host_read_done && !irq_oe_n);
  cover property (adc_capture && pad_sel == 2'h2);
endmodule
bind tf_touch_filter tf_touch_filter_chk u_chk (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_read_done(host_read_done), .pad_sel(pad_sel),
  .charge_en(charge_en), .discharge_en(discharge_en), .adc_capture(adc_capture),
  .touch_status(touch_status), .baseline_data(baseline_data), .irq_out(irq_out),
  .irq_oe_n(irq_oe_n));
`default_nettype wire

// ==== sim/tf_pad_model.sv ====
// Purpose: electrode and converter model answering the filter's captures
// Assumes: one steady level per pad, set by the bench
// Notes: data outside a capture cycle is deliberately wrong
`default_nettype none
module tf_pad_model (
  input wire logic [1:0] pad_sel,
  input wire logic adc_capture,
  input wire logic [9:0] lvl0,
  input wire logic [9:0] lvl1,
  input wire logic [9:0] lvl2,
  output logic [9:0] adc_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] level;
  assign level = (pad_sel == 2'h0) ? lvl0 : (pad_sel == 2'h1) ? lvl1 : lvl2;
  // inverted when not sampled, so a capture on the wrong cycle shows up
  assign adc_data = adc_capture ? level : ~level;
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Purpose: self-checking bench for the touch filter
// Assumes: shortened millisecond tick, default timing register
// Notes: the seed and touch phases change pad levels right after a filtered update
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic host_read_done = 1'b0;
  logic [9:0] lvl0 = 10'h1f4;
  logic [9:0] lvl1 = 10'h258;
  logic [9:0] lvl2 = 10'h2bc;
  logic [7:0] reg_rdata;
  logic [1:0] pad_sel;
  logic charge_en, discharge_en, adc_capture, irq_out, irq_oe_n;
  logic [9:0] adc_data;
  logic [2:0] touch_status;
  logic [29:0] filtered_data, baseline_data;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  tf_touch_filter #(.SAMPLE_TICK_CYCLES(20), .NUM_PADS(3)) u_dut (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .host_read_done(host_read_done), .pad_sel(pad_sel),
    .charge_en(charge_en), .discharge_en(discharge_en), .adc_capture(adc_capture),
    .adc_data(adc_data), .touch_status(touch_status), .filtered_data(filtered_data),
    .baseline_data(baseline_data), .irq_out(irq_out), .irq_oe_n(irq_oe_n));
  tf_pad_model u_pads (.pad_sel(pad_sel), .adc_capture(adc_capture), .lvl0(lvl0), .lvl1(lvl1),
    .lvl2(lvl2), .adc_data(adc_data));
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // the whole run takes about 35000 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic test_registers;
    logic [7:0] d;
    for (int i = 0; i < 9; i++) begin
      reg_read(8'h26 + 8'(i), d);
      check(d, (i < 2) ? 32'h1 : 32'h0);
    end
    reg_read(8'h41, d);
    check(d, 32'h0);
    reg_read(8'h43, d);
    check(d, 32'h20);
    reg_write(8'h26, 8'hff);
    reg_read(8'h26, d);
    check(d, 32'h3f);
    reg_write(8'h27, 8'hff);
    reg_read(8'h27, d);
    check(d, 32'h3f);
    reg_write(8'h28, 8'hff);
    reg_read(8'h28, d);
    check(d, 32'h0f);
    reg_write(8'h30, 8'hff);
    reg_read(8'h30, d);
    check(d, 32'h0);
    reg_write(8'h26, 8'h04);
    reg_write(8'h27, 8'h05);
    reg_write(8'h28, 8'h00);
    reg_write(8'h29, 8'h20);
    reg_write(8'h2a, 8'h10);
    reg_read(8'h2a, d);
    check(d, 32'h10);
  endtask
  task automatic test_charge_time(input logic [31:0] exp);
    int n;
    n = 0;
    while (charge_en !== 1'b0 && n < 5000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    n = 0;
    while (charge_en !== 1'b1 && n < 5000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    n = 0;
    while (charge_en === 1'b1 && n < 5000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(n, exp);
  endtask
  // returns just after the sequencer has begun a fresh round on pad 0
  task automatic wait_round;
    int n;
    n = 0;
    while (pad_sel !== 2'h2 && n < 9000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    while (pad_sel !== 2'h0 && n < 18000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask
  // returns three cycles after the expected block average first appears
  task automatic wait_filtered(input logic [29:0] exp);
    for (int i = 0; i < 15000; i++) begin
      @(posedge ref_clk);
      #1;
      if (filtered_data === exp) break;
    end
    check(filtered_data, exp);
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic test_seed;
    wait_filtered({10'h2bc, 10'h258, 10'h1f4});
    check(baseline_data, {10'h2bc, 10'h258, 10'h1f4});
    check(touch_status, 32'h0);
    @(posedge ref_clk);
    lvl0 <= 10'h1c2;
    lvl1 <= 10'h25b;
    lvl2 <= 10'h2d0;
  endtask
  task automatic test_touch;
    wait_filtered({10'h2d0, 10'h25b, 10'h1c2});
    check(touch_status, 32'h1);
    check(baseline_data[9:0], 32'h1f4);
    check(baseline_data[19:10], 32'h25b);
    check(baseline_data[29:20], 32'h2c1);
    check(irq_oe_n, 32'h0);
    @(posedge ref_clk);
    host_read_done <= 1'b1;
    @(posedge ref_clk);
    host_read_done <= 1'b0;
    #1;
    check(irq_oe_n, 32'h1);
    reg_write(8'h28, 8'h01);
    lvl0 <= 10'h1ef;
  endtask
  task automatic test_release;
    // pad 0 updates first and already completes the expected vector
    wait_filtered({10'h2d0, 10'h25b, 10'h1ef});
    check(touch_status, 32'h0);
    check(baseline_data[9:0], 32'h1f4);
    check(irq_oe_n, 32'h0);
    wait_round();
    // code 1 needs two over-limit samples, so one block leaves pad 2 unmoved
    check(baseline_data[29:20], 32'h2c1);
  endtask
  task automatic test_reconfig;
    logic [7:0] d;
    int n;
    int caps;
    reg_write(8'h41, 8'h40);
    reg_write(8'h43, 8'h48);
    reg_read(8'h41, d);
    check(d, 32'h40);
    reg_read(8'h43, d);
    check(d, 32'h48);
    wait_round();
    n = 0;
    caps = 0;
    while (pad_sel === 2'h0 && n < 6000) begin
      @(posedge ref_clk);
      #1;
      if (adc_capture === 1'b1) caps++;
      n++;
    end
    check(caps, 32'ha);
    test_charge_time(32'h7d);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    test_registers();
    test_charge_time(32'h3f);
    test_seed();
    test_touch();
    test_release();
    test_reconfig();
    end_sim();
  end
endmodule
`default_nettype wire
